/* File: shared/qbs_pkg.sv */
// shared constants and types for the burst sram port
package qbs_pkg;

    // ------------------------------------------------------------
    // data layout
    // ------------------------------------------------------------
    localparam int WORD_W   = 18;
    localparam int BEATS    = 4;
    localparam int ROW_W    = WORD_W * BEATS;
    localparam int ADDR_W   = 4;
    localparam int DEPTH    = 1 << ADDR_W;
    localparam int BWS_W    = 2;
    localparam int BYTE0_HI = 8;
    localparam int BYTE1_LO = 9;

    // ------------------------------------------------------------
    // half-cycle pipeline positions (one step per k or k-bar rise)
    // ------------------------------------------------------------
    localparam int         PIPE_LEN      = 5;
    localparam logic [2:0] STD_PRE_IDX   = 3'h3;
    localparam logic [2:0] STD_START_IDX = 3'h4;
    localparam logic [2:0] LEG_PRE_IDX   = 3'h0;
    localparam logic [2:0] LEG_START_IDX = 3'h1;
    localparam logic [2:0] WR_FWD_IDX    = 3'h1;
    localparam logic [2:0] CAP_OFS       = 3'h1;
    localparam logic [1:0] FIRST_BEAT    = 2'h0;
    localparam logic [1:0] LAST_BEAT     = 2'h3;
    localparam logic [1:0] FLAG_END_BEAT = 2'h2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int IMP_PERIOD   = 1024;
    localparam int IMP_W        = $clog2(IMP_PERIOD);
    localparam int CLK_MHZ      = 50;
    localparam int PLL_LOCK_US  = 20;
    localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
    localparam int LOCK_W       = $clog2(PLL_LOCK_CYC + 1);
    localparam int K_IDLE_NS    = 1000;
    localparam int K_IDLE_CYC   = (K_IDLE_NS * CLK_MHZ + 999) / 1000;
    localparam int IDLE_W       = $clog2(K_IDLE_CYC + 1);

    typedef enum logic [1:0] {
        QBS_OP_IDLE,
        QBS_OP_READ,
        QBS_OP_WRITE
    } qbs_op_t;

endpackage

/* File: rtl/qbs_sync.sv */
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module qbs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // every bit passes the same two stages, so relative alignment holds
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule

/* File: rtl/qbs_port.sv */
// separate-port four-word burst sram: link sampling, arbitration, array and read path
`timescale 1ns/1ps

module qbs_port (
    input  wire logic                        core_clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        k_clk_i,
    input  wire logic                        k_clk_n_i,
    input  wire logic                        read_port_select_n_i,
    input  wire logic                        write_port_select_n_i,
    input  wire logic [qbs_pkg::BWS_W-1:0]   byte_write_select_n_i,
    input  wire logic                        pll_disable_n_i,
    input  wire logic [qbs_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [qbs_pkg::WORD_W-1:0]  wdata_i,
    output logic      [qbs_pkg::WORD_W-1:0]  rdata_o,
    output logic                             rdata_oe_o,
    output logic                             read_valid_flag_o,
    output logic      [1:0]                  echo_clock_pair_o,
    output logic                             imp_update_o,
    output logic                             pll_locked_o
);
    import qbs_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [WORD_W-1:0] word_of(input logic [ROW_W-1:0] row, input logic [1:0] i);
        word_of = row[i*WORD_W +: WORD_W];
    endfunction

    function automatic logic [WORD_W-1:0] merge_word(input logic [WORD_W-1:0] old_w,
                                                     input logic [WORD_W-1:0] new_w,
                                                     input logic [BWS_W-1:0] sel_n);
        merge_word = old_w;
        if (!sel_n[0]) begin
            merge_word[BYTE0_HI:0] = new_w[BYTE0_HI:0];
        end
        if (!sel_n[1]) begin
            merge_word[WORD_W-1:BYTE1_LO] = new_w[WORD_W-1:BYTE1_LO];
        end
    endfunction

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    localparam int SYNC_W = 5 + BWS_W + ADDR_W + WORD_W;

    // k-bar idles high: carried inverted so a cleared sync matches idle, no false rise
    wire  [SYNC_W-1:0] pin_raw = {k_clk_i, ~k_clk_n_i, read_port_select_n_i, write_port_select_n_i,
                                  pll_disable_n_i, byte_write_select_n_i, addr_i, wdata_i};
    logic [SYNC_W-1:0] pin_s;

    qbs_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk_i   (core_clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (pin_raw),
        .q_o     (pin_s)
    );

    wire              k_s    = pin_s[SYNC_W-1];
    wire              kb_s   = ~pin_s[SYNC_W-2];
    wire              rps_s  = pin_s[SYNC_W-3];
    wire              wps_s  = pin_s[SYNC_W-4];
    wire              pdis_s = pin_s[SYNC_W-5];
    wire [BWS_W-1:0]  bws_s  = pin_s[ADDR_W+WORD_W +: BWS_W];
    wire [ADDR_W-1:0] addr_s = pin_s[WORD_W +: ADDR_W];
    wire [WORD_W-1:0] d_s    = pin_s[WORD_W-1:0];

    logic k_p_q;
    logic kb_p_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            k_p_q  <= 1'b0;
            kb_p_q <= 1'b1;
        end else begin
            k_p_q  <= k_s;
            kb_p_q <= kb_s;
        end
    end

    wire k_rise  = k_s & ~k_p_q;
    wire kb_rise = kb_s & ~kb_p_q;
    wire hedge   = k_rise | kb_rise;
    wire k_any   = (k_s ^ k_p_q) | (kb_s ^ kb_p_q);
    wire legacy  = ~pdis_s;

    // ------------------------------------------------------------
    // arbitration at k rise
    // ------------------------------------------------------------
    qbs_op_t last_q;

    wire     rd_req = k_rise & ~rps_s;
    wire     wr_req = k_rise & ~wps_s;
    wire     rd_go  = rd_req & (last_q != QBS_OP_READ);
    wire     wr_go  = wr_req & (last_q != QBS_OP_WRITE) & ~rd_go;
    qbs_op_t last_d;
    assign   last_d = rd_go ? QBS_OP_READ : (wr_go ? QBS_OP_WRITE : QBS_OP_IDLE);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_q <= QBS_OP_IDLE;
        end else if (k_rise) begin
            last_q <= last_d;
        end
    end

    // ------------------------------------------------------------
    // half-cycle token pipelines
    // ------------------------------------------------------------
    logic [PIPE_LEN-1:0]             rd_tok_q;
    logic [PIPE_LEN-1:0]             rd_fwd_q;
    logic [PIPE_LEN-1:0][ADDR_W-1:0] rd_adr_q;
    logic [PIPE_LEN-1:0]             wr_tok_q;
    logic [PIPE_LEN-1:0][ADDR_W-1:0] wr_adr_q;

    // write begun on the previous k rise, same burst address
    wire fwd_hit = wr_tok_q[WR_FWD_IDX] & (wr_adr_q[WR_FWD_IDX] == addr_s);

    // tokens keep moving whatever the selects do, so bursts always finish
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_tok_q <= '0;
            rd_fwd_q <= '0;
            rd_adr_q <= '0;
            wr_tok_q <= '0;
            wr_adr_q <= '0;
        end else if (hedge) begin
            rd_tok_q <= {rd_tok_q[PIPE_LEN-2:0], rd_go};
            rd_fwd_q <= {rd_fwd_q[PIPE_LEN-2:0], fwd_hit};
            rd_adr_q <= {rd_adr_q[PIPE_LEN-2:0], addr_s};
            wr_tok_q <= {wr_tok_q[PIPE_LEN-2:0], wr_go};
            wr_adr_q <= {wr_adr_q[PIPE_LEN-2:0], addr_s};
        end
    end

    // ------------------------------------------------------------
    // write capture and array
    // ------------------------------------------------------------
    logic [ROW_W-1:0] mem_q [DEPTH];
    logic [ROW_W-1:0] wbuf_q;

    // only one write can sit in the capture window at a time
    wire              cap     = hedge & (|wr_tok_q[PIPE_LEN-1:1]);
    wire [1:0]        cap_idx = wr_tok_q[4] ? 2'h3 : (wr_tok_q[3] ? 2'h2 : (wr_tok_q[2] ? 2'h1 : 2'h0));
    wire [2:0]        cap_pos = {1'b0, cap_idx} + CAP_OFS;
    wire [ADDR_W-1:0] cap_adr = wr_adr_q[cap_pos];
    wire [WORD_W-1:0] cap_old = word_of(mem_q[cap_adr], cap_idx);
    wire [WORD_W-1:0] cap_new = merge_word(cap_old, d_s, bws_s);
    wire              commit  = cap & (cap_idx == LAST_BEAT);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wbuf_q <= '0;
        end else if (cap) begin
            wbuf_q[cap_idx*WORD_W +: WORD_W] <= cap_new;
        end
    end

    // the whole row lands at once, after its last word is in
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (commit) begin
            mem_q[cap_adr] <= {cap_new, wbuf_q[ROW_W-WORD_W-1:0]};
        end
    end

    // ------------------------------------------------------------
    // read burst engine
    // ------------------------------------------------------------
    logic             rd_busy_q;
    logic [1:0]       rd_beat_q;
    logic [ADDR_W-1:0] cur_adr_q;
    logic             cur_fwd_q;
    logic [ROW_W-1:0] obuf_q;
    logic [WORD_W-1:0] rdata_q;
    logic             oe_q;
    logic             flag_q;

    wire [2:0]  st_idx   = legacy ? LEG_START_IDX : STD_START_IDX;
    wire [2:0]  pre_idx  = legacy ? LEG_PRE_IDX : STD_PRE_IDX;
    wire        rd_start = hedge & rd_tok_q[st_idx];
    wire        rd_pre   = hedge & rd_tok_q[pre_idx];
    wire        rd_step  = hedge & rd_busy_q & ~rd_start;
    wire [1:0]  nxt_beat = rd_start ? FIRST_BEAT : rd_beat_q + 2'h1;

    // legacy latency is too short for a commit, so it reads the write buffer;
    // the long latency sees the row committed and snapshots it at the start
    wire [ADDR_W-1:0] fet_adr  = rd_start ? rd_adr_q[st_idx] : cur_adr_q;
    wire              fet_fwd  = legacy & (rd_start ? rd_fwd_q[st_idx] : cur_fwd_q);
    wire [ROW_W-1:0]  fet_row  = mem_q[fet_adr];
    wire [WORD_W-1:0] fet_word = fet_fwd ? word_of(wbuf_q, nxt_beat) : word_of(fet_row, nxt_beat);
    wire [WORD_W-1:0] out_word = (legacy | rd_start) ? fet_word : word_of(obuf_q, nxt_beat);
    wire              burst_done = ~rd_busy_q | (rd_beat_q == LAST_BEAT);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_busy_q <= 1'b0;
            rd_beat_q <= FIRST_BEAT;
            cur_adr_q <= '0;
            cur_fwd_q <= 1'b0;
            obuf_q    <= '0;
            rdata_q   <= '0;
        end else if (rd_start) begin
            rd_busy_q <= 1'b1;
            rd_beat_q <= FIRST_BEAT;
            cur_adr_q <= rd_adr_q[st_idx];
            cur_fwd_q <= rd_fwd_q[st_idx];
            obuf_q    <= fet_row;
            rdata_q   <= out_word;
        end else if (rd_step) begin
            if (rd_beat_q == LAST_BEAT) begin
                rd_busy_q <= 1'b0;
            end else begin
                rd_beat_q <= nxt_beat;
                rdata_q   <= out_word;
            end
        end
    end

    // outputs float from reset until the first burst
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oe_q   <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            if (rd_start) begin
                oe_q <= 1'b1;
            end else if (kb_rise & burst_done) begin
                oe_q <= 1'b0;
            end
            if (hedge) begin
                flag_q <= rd_pre | rd_start | (rd_busy_q & (rd_beat_q < FLAG_END_BEAT));
            end
        end
    end

    // ------------------------------------------------------------
    // echo clocks, impedance tick, pll lock
    // ------------------------------------------------------------
    logic [1:0]       echo_q;
    logic [IMP_W-1:0] imp_cnt_q;
    logic             imp_upd_q;
    logic [IDLE_W-1:0] idle_cnt_q;
    logic [LOCK_W-1:0] lock_cnt_q;
    logic             locked_q;

    wire imp_wrap  = imp_cnt_q == IMP_W'(IMP_PERIOD - 1);
    wire k_stopped = idle_cnt_q == IDLE_W'(K_IDLE_CYC);
    wire lock_clr  = legacy | k_stopped;
    wire lock_full = lock_cnt_q == LOCK_W'(PLL_LOCK_CYC);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            echo_q     <= 2'h0;
            imp_cnt_q  <= '0;
            imp_upd_q  <= 1'b0;
            idle_cnt_q <= '0;
            lock_cnt_q <= '0;
            locked_q   <= 1'b0;
        end else begin
            echo_q    <= {kb_s, k_s};
            imp_upd_q <= k_rise & imp_wrap;
            if (k_rise) begin
                imp_cnt_q <= imp_cnt_q + 1'b1;
            end
            if (k_any) begin
                idle_cnt_q <= '0;
            end else if (!k_stopped) begin
                idle_cnt_q <= idle_cnt_q + 1'b1;
            end
            if (lock_clr) begin
                lock_cnt_q <= '0;
            end else if (!lock_full) begin
                lock_cnt_q <= lock_cnt_q + 1'b1;
            end
            locked_q <= lock_full & ~lock_clr;
        end
    end

    assign rdata_o           = rdata_q;
    assign rdata_oe_o        = oe_q;
    assign read_valid_flag_o = flag_q;
    assign echo_clock_pair_o = echo_q;
    assign imp_update_o      = imp_upd_q;
    assign pll_locked_o      = locked_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    rd_back2back_a: assert property ((rd_req && last_q == QBS_OP_READ) |=> !rd_tok_q[0])
        else $error("second consecutive read was accepted");

    wr_back2back_a: assert property ((wr_req && last_q == QBS_OP_WRITE) |=> !wr_tok_q[0])
        else $error("second consecutive write was accepted");

    both_sel_prio_a: assert property ((rd_req && wr_req && last_q != QBS_OP_READ)
                                      |=> (rd_tok_q[0] && !wr_tok_q[0]))
        else $error("read did not win arbitration");

    burst_drive_a: assert property (rd_start |=> (rdata_oe_o && rd_busy_q && rd_beat_q == FIRST_BEAT))
        else $error("read burst did not start driving");

    burst_len_a: assert property ($fell(rd_busy_q) |-> $past(rd_beat_q) == LAST_BEAT)
        else $error("read burst ended before four words");

    valid_lead_a: assert property (rd_start |-> read_valid_flag_o)
        else $error("valid flag not raised before first word");

    tri_after_a: assert property ((kb_rise && !rd_busy_q && !rd_start) |=> !rdata_oe_o)
        else $error("read outputs not released after k-bar rise");

    row_store_a: assert property ((commit && bws_s == 2'h0)
                                  |=> word_of(mem_q[$past(cap_adr)], LAST_BEAT) == $past(d_s))
        else $error("last write word not stored in array");

    imp_tick_a: assert property (imp_upd_q |-> (imp_cnt_q == '0 && !$past(imp_upd_q)))
        else $error("impedance tick out of period");

    pll_lock_a: assert property ($rose(pll_locked_o) |-> (lock_cnt_q == LOCK_W'(PLL_LOCK_CYC) && pdis_s))
        else $error("pll lock raised early");

endmodule

/* File: verif/qbs_ctrl_model.sv */
// controller-side model: makes k and k-bar and plays queued pin slots
`timescale 1ns/1ps
module qbs_ctrl_model (
    input  wire logic        core_clk_i,
    input  wire logic        run_i,
    output logic             k_clk_o,
    output logic             k_clk_n_o,
    output logic             rps_n_o,
    output logic             wps_n_o,
    output logic [1:0]       bws_n_o,
    output logic [3:0]       addr_o,
    output logic [17:0]      wdata_o
);
    logic [25:0] slot_q[$];
    logic [2:0]  ph   = 3'h7;
    logic        busy = 1'b0;
    wire  [2:0]  nph  = ph + 3'h1;

    initial {k_clk_o, k_clk_n_o, rps_n_o, wps_n_o, bws_n_o, addr_o, wdata_o} = {4'b0111, 24'h0};

    // ------------------------------------------------------------
    // clock and slot playback
    // ------------------------------------------------------------
    // stopped clocks park k low, k-bar high, so a restart opens on a k rise
    // pins change mid-phase: two core cycles of setup and of hold per edge
    always @(posedge core_clk_i) begin
        ph <= run_i ? nph : 3'h7;
        k_clk_o <= run_i && nph < 3'h4;
        k_clk_n_o <= !(run_i && nph < 3'h4);
        if (run_i && nph[1:0] == 2'h2) begin
            if (slot_q.size() > 0 && (nph == 3'h6 || busy)) begin
                {rps_n_o, wps_n_o, bws_n_o, addr_o, wdata_o} <= slot_q.pop_front();
                busy <= 1'b1;
            end else begin
                // released lines flip so a stale value never passes for a live one
                {rps_n_o, wps_n_o} <= 2'b11;
                {bws_n_o, addr_o, wdata_o} <= ~{bws_n_o, addr_o, wdata_o};
                busy <= 1'b0;
            end
        end
    end
endmodule

/* File: verif/qbs_port_tb_top.sv */
// self-checking bench: reference model of the burst port against the design
`timescale 1ns/1ps
module qbs_port_tb_top;
    import qbs_pkg::*;
    logic              core_clk_i      = 1'b0;
    logic              rst_n_i         = 1'b0;
    logic              run             = 1'b0;
    logic              pll_disable_n_i = 1'b1;
    logic              k, kn, rps_n, wps_n, oe, vld, imp, lock;
    logic              k_d = 1'b0, kn_d = 1'b0, cmp = 1'b0;
    logic [BWS_W-1:0]  bws_n;
    logic [ADDR_W-1:0] addr, ra;
    logic [WORD_W-1:0] wdata, rdata;
    logic [1:0]        echo;
    int                bad_count = 0, samples_checked = 0, h = 0, kr = 0, cyc = 0, imps = 0, rs;
    logic              p_r[80], p_w[80];
    logic [3:0]        p_a[80], wq[1024];
    logic [17:0]       p_d[80], wd[1024], ew[1024], mem[16][4];
    logic [1:0]        p_b[80], wb[1024];
    bit                eo[1024], ef[1024], ev[1024], wv[1024];
    logic              lrd, lwr, ract, rmode, lastk;

    always #10 core_clk_i = ~core_clk_i;

    qbs_ctrl_model ctrl_u (.core_clk_i(core_clk_i), .run_i(run), .k_clk_o(k), .k_clk_n_o(kn),
        .rps_n_o(rps_n), .wps_n_o(wps_n), .bws_n_o(bws_n), .addr_o(addr), .wdata_o(wdata));

    qbs_port dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .k_clk_i(k), .k_clk_n_i(kn),
        .read_port_select_n_i(rps_n), .write_port_select_n_i(wps_n), .byte_write_select_n_i(bws_n),
        .pll_disable_n_i(pll_disable_n_i), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
        .rdata_oe_o(oe), .read_valid_flag_o(vld), .echo_clock_pair_o(echo), .imp_update_o(imp),
        .pll_locked_o(lock));

    // ------------------------------------------------------------
    // compare and closing
    // ------------------------------------------------------------
    task automatic chk_b(string n, logic e, logic g);
        samples_checked++;
        if (e !== g) begin
            bad_count++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk_w(string n, logic [17:0] e, logic [17:0] g);
        samples_checked++;
        if (e !== g) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // reference model, one call per k or k-bar rise
    // ------------------------------------------------------------
    task automatic on_edge(input logic isk);
        int   j;
        logic rgo, wgo;
        // write words sit on edges two to five after the start; the row lands on the fifth
        wd[h%1024] = wdata;
        wb[h%1024] = bws_n;
        if (h >= 5 && wv[(h-5)%1024]) begin
            for (int i = 0; i < 4; i++) begin
                if (!wb[(h-3+i)%1024][0]) mem[wq[(h-5)%1024]][i][8:0] = wd[(h-3+i)%1024][8:0];
                if (!wb[(h-3+i)%1024][1]) mem[wq[(h-5)%1024]][i][17:9] = wd[(h-3+i)%1024][17:9];
            end
            wv[(h-5)%1024] = 1'b0;
        end
        j = rs + (rmode ? 5 : 2);
        if (ract && h - rs == 2) begin
            for (int i = 0; i < 4; i++) ef[(j+i-1)%1024] = 1'b1;
            for (int i = j; i < ((j + 4) | 1); i++) eo[i%1024] = 1'b1;
        end
        // data taken once a write begun one k rise earlier has landed
        if (ract && h - rs == 3) begin
            for (int i = 0; i < 4; i++) begin
                ew[(j+i)%1024] = mem[ra][i];
                ev[(j+i)%1024] = 1'b1;
            end
            ract = 1'b0;
        end
        if (isk) begin
            rgo = !rps_n && !lrd;
            wgo = !wps_n && !lwr && !rgo;
            lrd = rgo;
            lwr = wgo;
            kr++;
            if (rgo) begin
                {ract, rs, ra, rmode} = {1'b1, h, addr, pll_disable_n_i};
            end
            if (wgo) begin
                wv[h%1024] = 1'b1;
                wq[h%1024] = addr;
            end
        end
        lastk = isk;
        h++;
    endtask

    task automatic compare(input int x);
        x = x % 1024;
        chk_b("data_valid", ef[x], vld);
        chk_b("read_enable", eo[x], oe);
        if (ev[x]) chk_w("read_word", ew[x], rdata);
        chk_b("echo_k", !lastk, echo[0]);
        chk_b("echo_kbar", lastk, echo[1]);
        {eo[x], ef[x], ev[x]} = 3'b000;
    endtask

    always @(posedge core_clk_i) begin
        k_d <= k;
        kn_d <= kn;
        cmp <= 1'b0;
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            complete_run();
        end
        if (!rst_n_i) begin
            {h, kr, imps} = '0;
            {lrd, lwr, ract} = 3'h0;
            mem = '{default: '0};
            wv = '{default: 1'b0};
        end else begin
            if (k && !k_d || kn && !kn_d) begin
                on_edge(k && !k_d);
                cmp <= 1'b1;
            end
            // outputs of an edge land three core cycles after it; look one cycle past detection
            if (cmp && h >= 2) compare(h - 2);
            if (imp === 1'b1) begin
                imps++;
                chk_b("imp_phase", 1'b1, kr % 1024 == 0);
            end
        end
    end

    // ------------------------------------------------------------
    // stimulus plans: one slot per edge, even slots on k rises
    // ------------------------------------------------------------
    task automatic clr();
        for (int i = 0; i < 80; i++) begin
            {p_r[i], p_w[i]} = 2'b11;
            {p_a[i], p_d[i], p_b[i]} = 24'($urandom);
        end
    endtask

    task automatic rd(int e, logic [3:0] a);
        {p_r[e], p_a[e]} = {1'b0, a};
    endtask

    task automatic wr(int e, logic [3:0] a, logic part);
        {p_w[e], p_a[e]} = {1'b0, a};
        for (int i = 2; i < 6; i++) p_b[e+i] = part ? 2'($urandom) : 2'h0;
    endtask

    task automatic go(int n);
        @(negedge core_clk_i);
        for (int i = 0; i < n; i++) ctrl_u.slot_q.push_back({p_r[i], p_w[i], p_b[i], p_a[i], p_d[i]});
        repeat (4 * n + 64) @(posedge core_clk_i);
    endtask

    task automatic done(string n);
        $display("test %s finished, mismatches %0d", n, bad_count);
    endtask

    initial begin
        void'($urandom(32'h5d5ff52b));
        repeat (16) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        chk_b("reset_enable", 1'b0, oe);
        chk_b("reset_valid", 1'b0, vld);
        run <= 1'b1;
        clr();
        for (int r = 0; r < 16; r++) wr(4 * r, 4'(r), r[0]);
        go(68);
        done("fill");
        clr();
        for (int r = 0; r < 16; r++) rd(4 * r, 4'(15 - r));
        go(64);
        done("readback");
        clr();
        rd(0, 4'h3);
        rd(2, 4'h4);
        wr(4, 4'h5, 1'b1);
        wr(6, 4'h6, 1'b1);
        rd(8, 4'h5);
        for (int i = 12; i < 36; i += 2) {p_r[i], p_w[i], p_a[i]} = {2'b00, 4'(i / 8)};
        go(44);
        done("refuse_and_arbitrate");
        pll_disable_n_i <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        chk_b("lock_legacy", 1'b0, lock);
        clr();
        wr(0, 4'h2, 1'b0);
        rd(2, 4'h2);
        rd(6, 4'h9);
        wr(8, 4'h9, 1'b1);
        rd(10, 4'h9);
        go(20);
        done("legacy");
        pll_disable_n_i <= 1'b1;
        for (int c = 0; c < 36; c++) begin
            clr();
            for (int i = 0; i < 60; i += 2) {p_r[i], p_w[i], p_a[i]} = {2'($urandom), 4'($urandom % 4)};
            go(60);
        end
        done("random_mix");
        chk_b("lock_on", 1'b1, lock);
        pll_disable_n_i <= 1'b0;
        repeat (20) @(posedge core_clk_i);
        chk_b("lock_off", 1'b0, lock);
        pll_disable_n_i <= 1'b1;
        repeat (950) @(posedge core_clk_i);
        chk_b("lock_early", 1'b0, lock);
        repeat (100) @(posedge core_clk_i);
        chk_b("lock_late", 1'b1, lock);
        run <= 1'b0;
        repeat (70) @(posedge core_clk_i);
        chk_b("lock_stopped", 1'b0, lock);
        chk_b("imp_count", 1'b1, imps == kr / 1024);
        done("pll_and_impedance");
        complete_run();
    end
endmodule
